// *** design/acc_pkg.sv ***
package acc_pkg;

  // register port geometry
  localparam int unsigned ACC_AW = 8;
  localparam int unsigned ACC_DW = 8;

  // register offsets
  localparam logic [ACC_AW-1:0] ACC_OFS_CLOCK_ROLE  = 8'h0D;
  localparam logic [ACC_AW-1:0] ACC_OFS_ADC_LIMIT   = 8'h0E;
  localparam logic [ACC_AW-1:0] ACC_OFS_DAC_LIMIT   = 8'h0F;
  localparam logic [ACC_AW-1:0] ACC_OFS_CONV_CTRL   = 8'h17;
  localparam logic [ACC_AW-1:0] ACC_OFS_CONV_RATIO  = 8'h18;

  // reset values
  localparam logic [ACC_DW-1:0] ACC_RST_CLOCK_ROLE  = 8'h00;
  localparam logic [ACC_DW-1:0] ACC_RST_ADC_LIMIT   = 8'h00;
  localparam logic [ACC_DW-1:0] ACC_RST_DAC_LIMIT   = 8'h00;
  localparam logic [ACC_DW-1:0] ACC_RST_CONV_CTRL   = 8'h00;
  localparam logic [ACC_DW-1:0] ACC_RST_CONV_RATIO  = 8'h00;

  // bits that software can change; read-only reserved bits are cleared
  localparam logic [ACC_DW-1:0] ACC_WMASK_CLOCK_ROLE = 8'hDF;
  localparam logic [ACC_DW-1:0] ACC_WMASK_ADC_LIMIT  = 8'hF8;
  localparam logic [ACC_DW-1:0] ACC_WMASK_DAC_LIMIT  = 8'hF8;
  localparam logic [ACC_DW-1:0] ACC_WMASK_CONV_CTRL  = 8'hC0;
  localparam logic [ACC_DW-1:0] ACC_WMASK_CONV_RATIO = 8'hFF;

  // value read back on an unmapped offset
  localparam logic [ACC_DW-1:0] ACC_RD_UNMAPPED      = 8'h00;

  // clock role register fields
  localparam int unsigned ACC_BIT_PRI_OVERRIDE  = 7;
  localparam int unsigned ACC_BIT_SEC_OVERRIDE  = 6;
  localparam int unsigned ACC_BIT_PRI_INT_FRAME_SYNC = 2;
  localparam int unsigned ACC_BIT_SEC_INT_FRAME_SYNC = 1;

  // channel limit register fields
  localparam int unsigned ACC_BIT_FORCE_CUSTOM  = 7;
  localparam int unsigned ACC_CH_MASK_LSB       = 3;
  localparam int unsigned ACC_CH_MASK_W         = 4;

  // converter control fields
  localparam int unsigned ACC_BIT_CONV_ENABLE   = 7;
  localparam int unsigned ACC_BIT_AUTODET_OFF   = 6;

  // converter ratio fields
  localparam int unsigned ACC_BIT_MAIN_CUSTOM   = 7;
  localparam int unsigned ACC_BIT_MAIN_SELECT   = 6;
  localparam int unsigned ACC_RATIO_M_LSB       = 3;
  localparam int unsigned ACC_RATIO_N_LSB       = 0;
  localparam int unsigned ACC_RATIO_W           = 3;

  // ratio codes
  localparam logic [ACC_RATIO_W-1:0] ACC_RATIO_AUTO  = 3'h0;
  localparam logic [ACC_RATIO_W-1:0] ACC_RATIO_RES_A = 3'h5;
  localparam logic [ACC_RATIO_W-1:0] ACC_RATIO_RES_B = 3'h7;

  typedef enum logic [1:0] {
    ACC_MAIN_AUTO,
    ACC_MAIN_PRIMARY,
    ACC_MAIN_SECONDARY
  } acc_main_src_t;

  // per serial port clocking setup
  typedef struct packed {
    logic controller;
    logic bclk_out;
    logic frame_sync_out;
    logic autodetect_en;
    logic internal_frame_sync;
  } acc_port_cfg_t;

  // one decoded ratio term
  typedef struct packed {
    logic                   auto_infer;
    logic                   reserved;
    logic [ACC_RATIO_W-1:0] value;
  } acc_ratio_t;

  // rate converter setup
  typedef struct packed {
    logic          enable;
    logic          autodetect_en;
    acc_main_src_t main_src;
    acc_ratio_t    ratio_m;
    acc_ratio_t    ratio_n;
  } acc_conv_cfg_t;

endpackage

// *** design/acc_ratio_decode.sv ***
`timescale 1ns/1ps
module acc_ratio_decode (
  // raw field
  input  wire logic [acc_pkg::ACC_RATIO_W-1:0] code,
  // decoded term
  output acc_pkg::acc_ratio_t                  ratio
);
  import acc_pkg::*;

  always_comb begin
    ratio            = '0;
    ratio.auto_infer = (code == ACC_RATIO_AUTO);
    ratio.reserved   = (code == ACC_RATIO_RES_A) ||
                       (code == ACC_RATIO_RES_B);
    // reserved codes give value zero so nothing downstream runs on them
    ratio.value      = ratio.reserved ? ACC_RATIO_AUTO : code;
  end

endmodule

// *** design/acc_config_regs.sv ***
// Function
// - primary override disables standard role, autodetect
// - override role 0: bclk in, frame_sync out
// - secondary override mirrors primary override behaviour
// - primary controller uses internal frame_sync when set
// - secondary controller uses internal frame_sync when set
// - adc force bit picks custom mask source
// - adc custom mask bits 6-3, channels 4..1
// - dac force bit picks custom mask source
// - dac custom mask bits 6-3, channels 4..1
// - converter runs only while enable bit set
// - autodetect off bit disables rate detection
// - main rate custom bit enables manual selection
// - main select: 0 primary, 1 secondary port
// - numerator m: 0 auto, 5/7 reserved
// - denominator n decodes like the numerator
`timescale 1ns/1ps
module acc_config_regs (
  // clock and reset
  input  wire logic                               clock,
  input  wire logic                               rst,
  // register port
  input  wire logic [acc_pkg::ACC_AW-1:0]         reg_addr,
  input  wire logic                               reg_wr_en,
  input  wire logic                               reg_rd_en,
  input  wire logic [acc_pkg::ACC_DW-1:0]         reg_wdata,
  output logic      [acc_pkg::ACC_DW-1:0]         reg_rdata,
  output logic                                    reg_ack,
  output logic                                    reg_unmapped,
  output logic                                    reg_reserved_write,
  // role bits held elsewhere in the map
  input  wire logic                               primary_port_role,
  input  wire logic                               secondary_port_role,
  // default channel limits from the max channel select settings
  input  wire logic [acc_pkg::ACC_CH_MASK_W-1:0]  adc_max_channel_select,
  input  wire logic [acc_pkg::ACC_CH_MASK_W-1:0]  dac_max_channel_select,
  // serial port clocking
  output acc_pkg::acc_port_cfg_t                  primary_serial_port,
  output acc_pkg::acc_port_cfg_t                  secondary_serial_port,
  // dynamic mode channel limits
  output logic      [acc_pkg::ACC_CH_MASK_W-1:0]  adc_channel_enable,
  output logic      [acc_pkg::ACC_CH_MASK_W-1:0]  dac_channel_enable,
  // rate converter
  output acc_pkg::acc_conv_cfg_t                  converter_cfg,
  output logic                                    converter_ratio_error
);
  import acc_pkg::*;

  typedef struct packed {
    logic [ACC_DW-1:0]        clock_role;
    logic [ACC_DW-1:0]        adc_limit;
    logic [ACC_DW-1:0]        dac_limit;
    logic [ACC_DW-1:0]        conv_ctrl;
    logic [ACC_DW-1:0]        conv_ratio;
    logic [ACC_DW-1:0]        rdata;
    logic                     ack;
    logic                     unmapped;
    logic                     reserved_write;
    acc_port_cfg_t            pri_cfg;
    acc_port_cfg_t            sec_cfg;
    logic [ACC_CH_MASK_W-1:0] adc_en;
    logic [ACC_CH_MASK_W-1:0] dac_en;
    acc_conv_cfg_t            conv_cfg;
    logic                     ratio_error;
  } acc_state_t;

  acc_state_t                        state_ff;
  acc_state_t                        nxt_state;
  logic       [ACC_RATIO_W-1:0]      ratio_code [2];
  acc_ratio_t                        ratio_dec  [2];
  logic                              hit_clock_role;
  logic                              hit_adc_limit;
  logic                              hit_dac_limit;
  logic                              hit_conv_ctrl;
  logic                              hit_conv_ratio;
  logic                              hit_any;
  logic       [ACC_DW-1:0]           wmask;

  // role resolution shared by both ports
  function automatic acc_port_cfg_t port_setup(
    input logic override,
    input logic role,
    input logic use_int_frame_sync
  );
    acc_port_cfg_t cfg;
    cfg = '0;
    if (override) begin
      // directions split: bclk and frame sync go opposite ways
      cfg.controller     = role;
      cfg.bclk_out       = role;
      cfg.frame_sync_out = ~role;
      cfg.autodetect_en  = 1'b0;
    end else begin
      cfg.controller     = role;
      cfg.bclk_out       = role;
      cfg.frame_sync_out = role;
      cfg.autodetect_en  = 1'b1;
    end
    // internal frame sync only has meaning when this end is controller
    cfg.internal_frame_sync = role & use_int_frame_sync;
    return cfg;
  endfunction

  // ratio fields decoded by one decoder instance each
  assign ratio_code[0] = state_ff.conv_ratio[ACC_RATIO_M_LSB +: ACC_RATIO_W];
  assign ratio_code[1] = state_ff.conv_ratio[ACC_RATIO_N_LSB +: ACC_RATIO_W];

  generate
    for (genvar i = 0; i < 2; i++) begin : g_ratio
      acc_ratio_decode u_dec (
        .code  (ratio_code[i]),
        .ratio (ratio_dec[i])
      );
    end
  endgenerate

  // address decode
  always_comb begin
    hit_clock_role = (reg_addr == ACC_OFS_CLOCK_ROLE);
    hit_adc_limit  = (reg_addr == ACC_OFS_ADC_LIMIT);
    hit_dac_limit  = (reg_addr == ACC_OFS_DAC_LIMIT);
    hit_conv_ctrl  = (reg_addr == ACC_OFS_CONV_CTRL);
    hit_conv_ratio = (reg_addr == ACC_OFS_CONV_RATIO);
    hit_any        = hit_clock_role | hit_adc_limit | hit_dac_limit |
                     hit_conv_ctrl | hit_conv_ratio;
    wmask = '0;
    if (hit_clock_role) begin
      wmask = ACC_WMASK_CLOCK_ROLE;
    end else if (hit_adc_limit) begin
      wmask = ACC_WMASK_ADC_LIMIT;
    end else if (hit_dac_limit) begin
      wmask = ACC_WMASK_DAC_LIMIT;
    end else if (hit_conv_ctrl) begin
      wmask = ACC_WMASK_CONV_CTRL;
    end else if (hit_conv_ratio) begin
      wmask = ACC_WMASK_CONV_RATIO;
    end
  end

  always_comb begin
    nxt_state                = state_ff;
    nxt_state.ack            = 1'b0;
    nxt_state.unmapped       = 1'b0;
    nxt_state.reserved_write = 1'b0;

    // read returns the value before any write in the same cycle
    if (reg_rd_en) begin
      nxt_state.ack = 1'b1;
      if (hit_clock_role) begin
        nxt_state.rdata = state_ff.clock_role;
      end else if (hit_adc_limit) begin
        nxt_state.rdata = state_ff.adc_limit;
      end else if (hit_dac_limit) begin
        nxt_state.rdata = state_ff.dac_limit;
      end else if (hit_conv_ctrl) begin
        nxt_state.rdata = state_ff.conv_ctrl;
      end else if (hit_conv_ratio) begin
        nxt_state.rdata = state_ff.conv_ratio;
      end else begin
        nxt_state.rdata    = ACC_RD_UNMAPPED;
        nxt_state.unmapped = 1'b1;
      end
    end

    // writes; read-only bits keep their zero
    if (reg_wr_en) begin
      nxt_state.ack = 1'b1;
      if (!hit_any) begin
        nxt_state.unmapped = 1'b1;
      end
      // flag software that breaks the reserved-bit contract
      nxt_state.reserved_write = hit_any & |(reg_wdata & ~wmask);
      if (hit_clock_role) begin
        nxt_state.clock_role = reg_wdata & ACC_WMASK_CLOCK_ROLE;
      end
      if (hit_adc_limit) begin
        nxt_state.adc_limit = reg_wdata & ACC_WMASK_ADC_LIMIT;
      end
      if (hit_dac_limit) begin
        nxt_state.dac_limit = reg_wdata & ACC_WMASK_DAC_LIMIT;
      end
      if (hit_conv_ctrl) begin
        nxt_state.conv_ctrl = reg_wdata & ACC_WMASK_CONV_CTRL;
      end
      if (hit_conv_ratio) begin
        nxt_state.conv_ratio = reg_wdata & ACC_WMASK_CONV_RATIO;
      end
    end

    // settings derived from the stored fields, one cycle behind a write
    nxt_state.pri_cfg = port_setup(
      state_ff.clock_role[ACC_BIT_PRI_OVERRIDE],
      primary_port_role,
      state_ff.clock_role[ACC_BIT_PRI_INT_FRAME_SYNC]
    );
    nxt_state.sec_cfg = port_setup(
      state_ff.clock_role[ACC_BIT_SEC_OVERRIDE],
      secondary_port_role,
      state_ff.clock_role[ACC_BIT_SEC_INT_FRAME_SYNC]
    );

    if (state_ff.adc_limit[ACC_BIT_FORCE_CUSTOM]) begin
      nxt_state.adc_en =
        state_ff.adc_limit[ACC_CH_MASK_LSB +: ACC_CH_MASK_W];
    end else begin
      nxt_state.adc_en = adc_max_channel_select;
    end

    if (state_ff.dac_limit[ACC_BIT_FORCE_CUSTOM]) begin
      nxt_state.dac_en =
        state_ff.dac_limit[ACC_CH_MASK_LSB +: ACC_CH_MASK_W];
    end else begin
      nxt_state.dac_en = dac_max_channel_select;
    end

    nxt_state.conv_cfg.enable =
      state_ff.conv_ctrl[ACC_BIT_CONV_ENABLE];
    nxt_state.conv_cfg.autodetect_en =
      ~state_ff.conv_ctrl[ACC_BIT_AUTODET_OFF];

    if (!state_ff.conv_ratio[ACC_BIT_MAIN_CUSTOM]) begin
      nxt_state.conv_cfg.main_src = ACC_MAIN_AUTO;
    end else if (state_ff.conv_ratio[ACC_BIT_MAIN_SELECT]) begin
      nxt_state.conv_cfg.main_src = ACC_MAIN_SECONDARY;
    end else begin
      nxt_state.conv_cfg.main_src = ACC_MAIN_PRIMARY;
    end

    nxt_state.conv_cfg.ratio_m = ratio_dec[0];
    nxt_state.conv_cfg.ratio_n = ratio_dec[1];
    // a reserved code only matters while the converter would use it
    nxt_state.ratio_error = state_ff.conv_ctrl[ACC_BIT_CONV_ENABLE] &
                            (ratio_dec[0].reserved | ratio_dec[1].reserved);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff            <= '0;
      state_ff.clock_role <= ACC_RST_CLOCK_ROLE;
      state_ff.adc_limit  <= ACC_RST_ADC_LIMIT;
      state_ff.dac_limit  <= ACC_RST_DAC_LIMIT;
      state_ff.conv_ctrl  <= ACC_RST_CONV_CTRL;
      state_ff.conv_ratio <= ACC_RST_CONV_RATIO;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs straight from the state register
  assign reg_rdata             = state_ff.rdata;
  assign reg_ack               = state_ff.ack;
  assign reg_unmapped          = state_ff.unmapped;
  assign reg_reserved_write    = state_ff.reserved_write;
  assign primary_serial_port   = state_ff.pri_cfg;
  assign secondary_serial_port = state_ff.sec_cfg;
  assign adc_channel_enable    = state_ff.adc_en;
  assign dac_channel_enable    = state_ff.dac_en;
  assign converter_cfg         = state_ff.conv_cfg;
  assign converter_ratio_error = state_ff.ratio_error;

endmodule

// *** verif/acc_config_regs_chk.sv ***
`timescale 1ns/1ps
module acc_config_regs_chk
  import acc_pkg::*;
(
  // clock and reset
  input wire logic                              clock,
  input wire logic                              rst,
  // register port
  input wire logic [acc_pkg::ACC_AW-1:0]        reg_addr,
  input wire logic                              reg_wr_en,
  input wire logic                              reg_rd_en,
  input wire logic [acc_pkg::ACC_DW-1:0]        reg_wdata,
  input wire logic                              reg_ack,
  input wire logic                              reg_unmapped,
  input wire logic                              reg_reserved_write,
  // derived setup
  input wire logic                              primary_port_role,
  input wire acc_pkg::acc_port_cfg_t            primary_serial_port,
  input wire acc_pkg::acc_port_cfg_t            secondary_serial_port,
  input wire logic [acc_pkg::ACC_CH_MASK_W-1:0] adc_channel_enable,
  input wire acc_pkg::acc_conv_cfg_t            converter_cfg,
  input wire logic                              converter_ratio_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic mapped;
  assign mapped = reg_addr inside {ACC_OFS_CLOCK_ROLE, ACC_OFS_ADC_LIMIT,
    ACC_OFS_DAC_LIMIT, ACC_OFS_CONV_CTRL, ACC_OFS_CONV_RATIO};

  sequence s_conv_wr;
    reg_wr_en && reg_addr == ACC_OFS_CONV_CTRL;
  endsequence
  sequence s_adc_force;
    reg_wr_en && reg_addr == ACC_OFS_ADC_LIMIT && reg_wdata[7];
  endsequence

  // outputs still hold reset zeros one edge after release
  a_unmapped_pulse: assert property (
    (reg_wr_en || reg_rd_en) && !mapped |=> reg_unmapped && reg_ack)
    else $error("unmapped access not flagged");
  a_reserved_flag: assert property (
    s_conv_wr ##0 (reg_wdata[5:0] != 6'h00) |=> reg_reserved_write)
    else $error("reserved write not flagged");
  a_pri_override_dir: assert property (
    !$past(rst) |-> (primary_serial_port.bclk_out ^
      primary_serial_port.frame_sync_out) ==
      !primary_serial_port.autodetect_en)
    else $error("primary direction mismatch");
  a_pri_bclk_role: assert property (
    !$past(rst) |-> primary_serial_port.bclk_out == $past(primary_port_role))
    else $error("primary bit clock direction wrong");
  a_sec_override_dir: assert property (
    !$past(rst) |-> (secondary_serial_port.bclk_out ^
      secondary_serial_port.frame_sync_out) ==
      !secondary_serial_port.autodetect_en)
    else $error("secondary direction mismatch");
  a_int_frame_sync_ctrl: assert property (
    primary_serial_port.internal_frame_sync |-> primary_serial_port.controller)
    else $error("internal frame sync outside controller mode");
  a_adc_force_mask: assert property (
    s_adc_force |-> ##2 adc_channel_enable == $past(reg_wdata[6:3], 2))
    else $error("adc custom limit not applied");
  a_conv_enable_bits: assert property (
    s_conv_wr |-> ##2 converter_cfg.enable == $past(reg_wdata[7], 2) &&
      converter_cfg.autodetect_en == !$past(reg_wdata[6], 2))
    else $error("converter control not applied");
  a_ratio_error_lvl: assert property (
    converter_ratio_error == (converter_cfg.enable &&
      (converter_cfg.ratio_m.reserved || converter_cfg.ratio_n.reserved)))
    else $error("ratio error level wrong");
endmodule

bind acc_config_regs acc_config_regs_chk u_chk (.*);

// *** verif/acc_config_regs_tb.sv ***
`timescale 1ns/1ps
module acc_config_regs_tb;
  import acc_pkg::*;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t got %h exp %h", $time, g, e); end end

  logic                clock = 1'b0;
  logic                rst = 1'b1;
  logic [7:0]          reg_addr = 8'h00;
  logic                reg_wr_en = 1'b0;
  logic                reg_rd_en = 1'b0;
  logic [7:0]          reg_wdata = 8'h00;
  logic                prole = 1'b0;
  logic                srole = 1'b0;
  logic [3:0]          adc_sel = 4'h0;
  logic [3:0]          dac_sel = 4'h0;
  logic [7:0]          reg_rdata;
  logic                reg_ack, reg_unmapped, reg_reserved_write, rerr;
  acc_port_cfg_t       pps, sps;
  logic [3:0]          adc_en, dac_en;
  acc_conv_cfg_t       conv;
  acc_main_src_t       ms;
  acc_ratio_t          r1, r2;
  logic [2:0]          c;
  int                  fails = 0;
  int                  checked = 0;
  int                  i, j;
  logic [7:0]          ofs [5] = '{8'h0D, 8'h0E, 8'h0F, 8'h17, 8'h18};
  logic [7:0]          msk [5] = '{8'hDF, 8'hF8, 8'hF8, 8'hC0, 8'hFF};
  logic [7:0]          cv  [4] = '{8'h06, 8'h86, 8'hC6, 8'h42};
  logic [7:0]          ch  [4] = '{8'h00, 8'hC8, 8'hB0, 8'h30};
  logic [3:0]          ce  [4] = '{4'h5, 4'h9, 4'h6, 4'hA};

  always #5 clock = ~clock;

  acc_config_regs DUT (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_unmapped(reg_unmapped),
    .reg_reserved_write(reg_reserved_write), .primary_port_role(prole),
    .secondary_port_role(srole), .adc_max_channel_select(adc_sel),
    .dac_max_channel_select(dac_sel), .primary_serial_port(pps),
    .secondary_serial_port(sps), .adc_channel_enable(adc_en),
    .dac_channel_enable(dac_en), .converter_cfg(conv),
    .converter_ratio_error(rerr));

  // one strobe, then ack checked while it still stands
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = w;
    reg_rd_en = !w;
    @(negedge clock);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    `CHK(reg_ack, 1'b1)
  endtask

  function automatic acc_port_cfg_t pexp(logic o, logic r, logic f);
    return '{r, r, o ? !r : r, !o, r & f};
  endfunction

  function automatic acc_ratio_t rexp(logic [2:0] k);
    logic res;
    res = (k == 3'h5) || (k == 3'h7);
    return '{k == 3'h0, res, res ? 3'h0 : k};
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    tally_and_finish;
  end

  initial begin
    repeat (6) @(negedge clock);
    rst = 1'b0;
    for (i = 0; i < 5; i++) begin
      access(1'b0, ofs[i], 8'h00);
      `CHK(reg_rdata, 8'h00)
      access(1'b1, ofs[i], 8'hFF);
      `CHK(reg_reserved_write, msk[i] != 8'hFF)
      access(1'b0, ofs[i], 8'h00);
      `CHK(reg_rdata, msk[i])
      access(1'b1, ofs[i], 8'h00);
    end
    access(1'b1, 8'h10, 8'h55);
    `CHK(reg_unmapped, 1'b1)
    access(1'b0, 8'h10, 8'h00);
    `CHK(reg_rdata, 8'h00)
    $display("test registers done");
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 4; j++) begin
        {prole, srole} = j[1:0];
        access(1'b1, 8'h0D, cv[i]);
        @(negedge clock);
        `CHK(pps, pexp(cv[i][7], prole, cv[i][2]))
        `CHK(sps, pexp(cv[i][6], srole, cv[i][1]))
      end
    end
    $display("test port roles done");
    adc_sel = 4'h5;
    dac_sel = 4'hA;
    for (i = 0; i < 4; i++) begin
      access(1'b1, i < 2 ? 8'h0E : 8'h0F, ch[i]);
      @(negedge clock);
      `CHK(i < 2 ? adc_en : dac_en, ce[i])
    end
    $display("test channel limits done");
    access(1'b1, 8'h17, 8'h80);
    for (i = 0; i < 8; i++) begin
      c = i[2:0];
      r1 = rexp(c);
      r2 = rexp(3'h7 - c);
      ms = !c[0] ? ACC_MAIN_AUTO :
           c[1] ? ACC_MAIN_SECONDARY : ACC_MAIN_PRIMARY;
      access(1'b1, 8'h18, {c[0], c[1], c, 3'h7 - c});
      @(negedge clock);
      `CHK(conv, {1'b1, 1'b1, ms, r1, r2})
      `CHK(rerr, r1.reserved | r2.reserved)
    end
    access(1'b1, 8'h17, 8'h40);
    @(negedge clock);
    `CHK(conv.enable, 1'b0)
    `CHK(conv.autodetect_en, 1'b0)
    `CHK(rerr, 1'b0)
    $display("test converter done");
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    access(1'b0, 8'h18, 8'h00);
    `CHK(reg_rdata, 8'h00)
    $display("test second reset done");
    tally_and_finish;
  end
endmodule
